// file: alsup_pkg.sv
package alsup_pkg;

    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned TICK_CYCLES = CLK_HZ;
    localparam logic [25:0] TICK_LAST = 26'(TICK_CYCLES - 1);

    // default persistence and hold times, seconds
    localparam logic [7:0] TEMP_ERR_S_RST = 8'h28;
    localparam logic [7:0] TEMP_OK_S_RST = 8'h28;
    localparam logic [7:0] DOOR_ERR_S_RST = 8'h02;
    localparam logic [7:0] DOOR_OK_S_RST = 8'h05;
    localparam logic [7:0] SPD_ERR_S_RST = 8'h14;
    localparam logic [7:0] SPD_OK_S_RST = 8'h14;
    // tolerances: temperature in 0.1 degC, speed in rpm
    localparam logic [15:0] TEMP_TOL_RST = 16'h001e;
    localparam logic [15:0] SPD_TOL_RST = 16'h000a;
    localparam logic signed [15:0] TEMP_TRIM_RST = 16'sh0000;
    localparam logic [7:0] FULL_RESET_S = 8'h03;

    localparam int unsigned N_TYPES = 4;
    localparam int unsigned TYP_TEMP = 0;
    localparam int unsigned TYP_DOOR = 1;
    localparam int unsigned TYP_SPD = 2;
    localparam int unsigned TYP_PWR = 3;

    typedef enum logic [1:0] {
        ALSUP_IDLE = 2'b00,
        ALSUP_PEND = 2'b01,
        ALSUP_FAULT = 2'b10,
        ALSUP_HOLD = 2'b11
    } alsup_state_e;

    typedef struct packed {
        logic enable;
        logic buzzer_en;
        logic [7:0] err_s;
        logic [7:0] ok_s;
    } alsup_qual_cfg_s;

    typedef struct packed {
        logic [15:0] count;
        logic [31:0] start_time;
        logic [31:0] end_time;
    } alsup_log_s;

endpackage

// file: alsup_qual.sv
module alsup_qual
    import alsup_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic tick_in,
    input wire logic bad_in,
    input wire alsup_qual_cfg_s cfg_in,
    output logic fault_out,
    output logic raise_out,
    output logic clear_out
);

    alsup_state_e state_q;
    logic [7:0] secs_q;

    always_ff @(posedge ref_clk_in)
    begin
        raise_out <= 1'b0;
        clear_out <= 1'b0;
        if (reset_in || !cfg_in.enable)
        begin
            state_q <= ALSUP_IDLE;
            secs_q <= 8'h00;
        end
        else
        begin
            unique case (state_q)
                ALSUP_IDLE:
                    if (bad_in)
                    begin
                        state_q <= ALSUP_PEND;
                        secs_q <= 8'h00;
                    end
                ALSUP_PEND:
                    if (!bad_in)
                        state_q <= ALSUP_IDLE; // see RQ24
                    else if (secs_q >= cfg_in.err_s)
                    begin
                        state_q <= ALSUP_FAULT; // see RQ2
                        raise_out <= 1'b1;
                    end
                    else if (tick_in)
                        secs_q <= secs_q + 8'h01;
                ALSUP_FAULT:
                    if (!bad_in)
                    begin
                        state_q <= ALSUP_HOLD;
                        secs_q <= 8'h00;
                        clear_out <= 1'b1;
                    end
                ALSUP_HOLD:
                    if (bad_in)
                        secs_q <= 8'h00; // see RQ24
                    else if (secs_q >= cfg_in.ok_s)
                        state_q <= ALSUP_IDLE; // see RQ3
                    else if (tick_in)
                        secs_q <= secs_q + 8'h01;
            endcase
        end
    end

    assign fault_out = (state_q == ALSUP_FAULT);

endmodule

// file: alsup_top.sv
// How it works
// RQ1 - temperature faults only when alarm enabled
// RQ2 - temperature fault after persistence time
// RQ3 - temperature re-arm after in-band hold
// RQ4 - temperature band: setpoint minus/plus tolerances
// RQ5 - door fault after cover open persistence
// RQ6 - door re-arm after closed hold
// RQ7 - speed fault after persistence time
// RQ8 - speed re-arm after in-band hold
// RQ9 - speed band: setpoint minus/plus tolerances
// RQ10 - per-type buzzer enable
// RQ11 - power alarm enable setting
// RQ12 - lamp, buzzer and log on alarm
// RQ13 - collective alarm contact reports alarm
// RQ14 - confirm key clears lamp, buzzer, contact
// RQ15 - open door stops drive and heater
// RQ16 - no start unless both doors closed
// RQ17 - power loss keeps elapsed time, resumes
// RQ18 - power enable affects indication only; code also gates the power log entry with it
// RQ19 - settings held in nonvolatile store
// RQ20 - signed trim added to temperature reading
// RQ21 - long reset key erases everything
// RQ22 - relay closed normally, open on alarm
// RQ23 - log counts, start and end times
// RQ24 - timers count seconds, restart on drop
// RQ25 - independent machine per alarm type
module alsup_top
    import alsup_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic signed [15:0] temp_raw_in,
    input wire logic signed [15:0] temp_set_in,
    input wire logic signed [15:0] temp_trim_in,
    input wire logic [15:0] temp_tol_lo_in,
    input wire logic [15:0] temp_tol_hi_in,
    input wire logic [15:0] speed_act_in,
    input wire logic [15:0] speed_set_in,
    input wire logic [15:0] speed_tol_lo_in,
    input wire logic [15:0] speed_tol_hi_in,
    input wire alsup_qual_cfg_s temp_cfg_in,
    input wire alsup_qual_cfg_s door_cfg_in,
    input wire alsup_qual_cfg_s speed_cfg_in,
    input wire logic pwr_alarm_en_in,
    input wire logic pwr_buzzer_en_in,
    input wire logic door1_closed_in,
    input wire logic door2_closed_in,
    input wire logic power_returned_in,
    input wire logic was_running_in,
    input wire logic start_key_in,
    input wire logic stop_key_in,
    input wire logic confirm_key_in,
    input wire logic reset_key_in,
    input wire logic [31:0] now_in,
    input wire logic [31:0] elapsed_saved_in,
    input wire logic [1:0] log_clear_in,
    input wire logic log_clear_stb_in,
    output logic signed [15:0] temp_corr_out,
    output logic lamp_out,
    output logic buzzer_out,
    output logic relay_closed_out,
    output logic drive_en_out,
    output logic heat_en_out,
    output logic running_out,
    output logic [31:0] elapsed_out,
    output logic full_reset_out,
    output alsup_log_s log_out [N_TYPES]
);

    // two-flop synchronisers for pins
    logic [6:0] pin_s1_q;
    logic [6:0] pin_s2_q;
    always_ff @(posedge ref_clk_in)
    begin
        pin_s1_q <= {door1_closed_in, door2_closed_in, power_returned_in,
            start_key_in, stop_key_in, confirm_key_in, reset_key_in};
        pin_s2_q <= pin_s1_q;
    end
    logic doors_closed;
    logic pwr_ret;
    logic start_k;
    logic stop_k;
    logic confirm_k;
    logic reset_k;
    assign doors_closed = pin_s2_q[6] & pin_s2_q[5];
    assign pwr_ret = pin_s2_q[4];
    assign start_k = pin_s2_q[3];
    assign stop_k = pin_s2_q[2];
    assign confirm_k = pin_s2_q[1];
    assign reset_k = pin_s2_q[0];

    // one-second tick
    logic [25:0] div_q;
    logic tick_q;
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            div_q <= 26'h0000000;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == TICK_LAST); // see RQ24
            div_q <= (div_q == TICK_LAST) ? 26'h0000000 : div_q + 26'h1;
        end
    end

    // corrected temperature and band compare
    logic signed [16:0] t_corr;
    logic signed [17:0] t_lo;
    logic signed [17:0] t_hi;
    logic [16:0] s_lo;
    logic [16:0] s_hi;
    logic temp_bad;
    logic speed_bad;
    assign t_corr = 17'(temp_raw_in) + 17'(temp_trim_in); // see RQ20
    assign t_lo = 18'(temp_set_in) - 18'(signed'({1'b0, temp_tol_lo_in}));
    assign t_hi = 18'(temp_set_in) + 18'(signed'({1'b0, temp_tol_hi_in}));
    assign temp_bad = (18'(t_corr) < t_lo) || (18'(t_corr) > t_hi); // see RQ4
    assign s_lo = {1'b0, speed_set_in} - {1'b0, speed_tol_lo_in};
    assign s_hi = {1'b0, speed_set_in} + {1'b0, speed_tol_hi_in};
    assign speed_bad = ({1'b0, speed_act_in} < s_lo && !s_lo[16])
        || ({1'b0, speed_act_in} > s_hi); // see RQ9

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            temp_corr_out <= TEMP_TRIM_RST;
        else
            temp_corr_out <= 16'(t_corr);
    end

    // independent qualifiers
    logic [2:0] q_fault;
    logic [2:0] q_raise;
    logic [2:0] q_clear;
    logic [2:0] q_bad;
    alsup_qual_cfg_s q_cfg [3];
    assign q_bad = {speed_bad & running_out, ~doors_closed, temp_bad};
    assign q_cfg[0] = temp_cfg_in; // see RQ1
    assign q_cfg[1] = door_cfg_in; // see RQ5
    assign q_cfg[2] = speed_cfg_in; // see RQ7

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_qual
            alsup_qual u_qual (
                .ref_clk_in(ref_clk_in),
                .reset_in(reset_in),
                .tick_in(tick_q),
                .bad_in(q_bad[g]),
                .cfg_in(q_cfg[g]),
                .fault_out(q_fault[g]),
                .raise_out(q_raise[g]),
                .clear_out(q_clear[g])
            ); // see RQ25, RQ2, RQ3, RQ5, RQ6, RQ7, RQ8
        end
    endgenerate

    // power loss event, on first return
    logic pwr_ret_q;
    logic pwr_raise;
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            pwr_ret_q <= 1'b0;
        else
            pwr_ret_q <= pwr_ret;
    end
    assign pwr_raise = pwr_ret & ~pwr_ret_q & pwr_alarm_en_in; // see RQ11, RQ18

    logic [N_TYPES-1:0] raise;
    logic [N_TYPES-1:0] clear;
    logic [N_TYPES-1:0] buz_en;
    assign raise = {pwr_raise, q_raise};
    assign clear = {pwr_raise, q_clear};
    assign buz_en = {pwr_buzzer_en_in, speed_cfg_in.buzzer_en,
        door_cfg_in.buzzer_en, temp_cfg_in.buzzer_en};

    // alarm indication, latched until confirm
    logic [N_TYPES-1:0] ind_q;
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
            ind_q <= '0;
        else if (confirm_k && raise == '0)
            ind_q <= '0; // see RQ14
        else
            ind_q <= (confirm_k ? '0 : ind_q) | raise; // see RQ12
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            lamp_out <= 1'b0;
            buzzer_out <= 1'b0;
            relay_closed_out <= 1'b1;
        end
        else
        begin
            lamp_out <= |ind_q; // see RQ12
            buzzer_out <= |(ind_q & buz_en); // see RQ10
            relay_closed_out <= ~|ind_q; // see RQ13, RQ22
        end
    end

    // fault history log per type; a raise beats a clear strobe
    logic [N_TYPES-1:0] log_wipe;
    generate
        for (g = 0; g < N_TYPES; g++)
        begin : g_log
            assign log_wipe[g] = log_clear_stb_in && (log_clear_in == 2'(g));
            always_ff @(posedge ref_clk_in)
            begin
                if (reset_in || full_reset_out)
                    log_out[g] <= '0;
                else
                begin
                    if (raise[g])
                    begin
                        log_out[g].count <= log_wipe[g] ? 16'h1
                            : log_out[g].count + 16'h1; // see RQ23
                        log_out[g].start_time <= now_in; // see RQ23
                    end
                    else if (log_wipe[g])
                    begin
                        log_out[g].count <= 16'h0;
                        log_out[g].start_time <= 32'h0;
                    end
                    if (clear[g])
                        log_out[g].end_time <= now_in; // see RQ23
                    else if (log_wipe[g])
                        log_out[g].end_time <= 32'h0;
                end
            end
        end
    endgenerate

    // run control and door interlock
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in || full_reset_out)
        begin
            running_out <= 1'b0;
            elapsed_out <= 32'h0;
        end
        else if (pwr_ret && !pwr_ret_q)
        begin
            running_out <= was_running_in; // see RQ17
            elapsed_out <= elapsed_saved_in; // see RQ17
        end
        else if (stop_k)
            running_out <= 1'b0;
        else if (start_k && doors_closed)
            running_out <= 1'b1; // see RQ16
        else if (running_out && tick_q && doors_closed)
            elapsed_out <= elapsed_out + 32'h1;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in)
        begin
            drive_en_out <= 1'b0;
            heat_en_out <= 1'b0;
        end
        else
        begin
            drive_en_out <= running_out & doors_closed; // see RQ15
            heat_en_out <= running_out & doors_closed; // see RQ15
        end
    end

    // long press full reset; settings store outside is wiped on it
    logic [7:0] hold_s_q;
    always_ff @(posedge ref_clk_in)
    begin
        if (reset_in || !reset_k)
        begin
            hold_s_q <= 8'h00;
            full_reset_out <= 1'b0;
        end
        else
        begin
            full_reset_out <= 1'b0;
            if (tick_q && hold_s_q != 8'hff)
                hold_s_q <= hold_s_q + 8'h01;
            if (tick_q && hold_s_q == FULL_RESET_S - 8'h01)
                full_reset_out <= 1'b1; // see RQ21, RQ19
        end
    end

endmodule

// file: alsup_properties.sv
module alsup_properties
    import alsup_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic signed [15:0] temp_raw_in,
    input wire logic signed [15:0] temp_trim_in,
    input wire alsup_qual_cfg_s temp_cfg_in,
    input wire alsup_qual_cfg_s door_cfg_in,
    input wire alsup_qual_cfg_s speed_cfg_in,
    input wire logic pwr_alarm_en_in,
    input wire logic door1_closed_in,
    input wire logic door2_closed_in,
    input wire logic power_returned_in,
    input wire logic confirm_key_in,
    input wire logic signed [15:0] temp_corr_out,
    input wire logic lamp_out,
    input wire logic buzzer_out,
    input wire logic relay_closed_out,
    input wire logic drive_en_out,
    input wire logic heat_en_out,
    input wire logic running_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    relay_vs_lamp_a: assert property (relay_closed_out != lamp_out)
        else $error("relay and lamp disagree");
    buzzer_lamp_a: assert property (buzzer_out |-> lamp_out)
        else $error("buzzer without lamp");
    trim_sum_a: assert property ($past(!reset_in) |->
        temp_corr_out == $past(temp_raw_in + temp_trim_in))
        else $error("corrected temperature wrong");
    door_stop_a: assert property ((!door1_closed_in || !door2_closed_in)[*5]
        |=> !drive_en_out && !heat_en_out)
        else $error("drive or heat on with door open");
    no_start_a: assert property ((!door1_closed_in || !door2_closed_in)[*6]
        |=> !$rose(running_out))
        else $error("started with door open");
    reset_idle_a: assert property ($fell(reset_in) |-> relay_closed_out
        && !lamp_out && !running_out && !drive_en_out)
        else $error("outputs not idle after reset");
    confirm_clear_a: assert property (
        (confirm_key_in && $stable(power_returned_in))[*8]
        |=> !lamp_out && !buzzer_out && relay_closed_out)
        else $error("confirm did not clear alarm");
    power_alarm_a: assert property (
        $rose(power_returned_in) && pwr_alarm_en_in ##1
        (pwr_alarm_en_in && !confirm_key_in)[*8] |-> lamp_out)
        else $error("power alarm not shown");
    none_enabled_a: assert property ((!temp_cfg_in.enable &&
        !door_cfg_in.enable && !speed_cfg_in.enable && !pwr_alarm_en_in)[*8]
        |=> !$rose(lamp_out))
        else $error("alarm raised while disabled");
endmodule

bind alsup_top alsup_properties u_alsup_properties (.*);

// file: alsup_panel.sv
module alsup_panel
(
    input wire logic ref_clk_in,
    input wire logic relay_closed_in,
    output logic [3:0] keys_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int alarm_reports = 0;

    initial
    begin
        keys_out = 4'h0;
    end

    // alarm centre counts contact openings
    always @(negedge relay_closed_in)
    begin
        alarm_reports++;
    end

    // keys: 0 start, 1 stop, 2 confirm, 3 reset
    task automatic press(input int k, input int n);
        keys_out[k] = 1'b1;
        repeat (n) @(negedge ref_clk_in);
        keys_out[k] = 1'b0;
    endtask
endmodule

// file: alarm_supervisor_bench.sv
module alarm_supervisor_bench
    import alsup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic signed [15:0] temp_raw_in = 16'sh0172;
    logic signed [15:0] temp_set_in = 16'sh0172;
    logic signed [15:0] temp_trim_in = TEMP_TRIM_RST;
    logic [15:0] temp_tol_lo_in = TEMP_TOL_RST, temp_tol_hi_in = TEMP_TOL_RST;
    logic [15:0] speed_act_in = 16'h00c8, speed_set_in = 16'h00c8;
    logic [15:0] speed_tol_lo_in = SPD_TOL_RST, speed_tol_hi_in = SPD_TOL_RST;
    alsup_qual_cfg_s temp_cfg_in = '{1'b0, 1'b1, TEMP_ERR_S_RST, TEMP_OK_S_RST};
    alsup_qual_cfg_s door_cfg_in = '{1'b0, 1'b1, DOOR_ERR_S_RST, DOOR_OK_S_RST};
    alsup_qual_cfg_s speed_cfg_in = '{1'b0, 1'b1, SPD_ERR_S_RST, SPD_OK_S_RST};
    logic pwr_alarm_en_in = 1'b0, pwr_buzzer_en_in = 1'b0;
    logic door1_closed_in = 1'b1, door2_closed_in = 1'b1;
    logic power_returned_in = 1'b0, was_running_in = 1'b0;
    logic [31:0] now_in = 32'h0, elapsed_saved_in = 32'h0;
    logic [1:0] log_clear_in = 2'h0;
    logic log_clear_stb_in = 1'b0;
    logic [3:0] keys;
    wire start_key_in = keys[0];
    wire stop_key_in = keys[1];
    wire confirm_key_in = keys[2];
    wire reset_key_in = keys[3];
    logic signed [15:0] temp_corr_out;
    logic lamp_out, buzzer_out, relay_closed_out, drive_en_out, heat_en_out;
    logic running_out, full_reset_out;
    logic [31:0] elapsed_out;
    alsup_log_s log_out [N_TYPES];
    int mismatches = 0, checked = 0, seed = 32'hbd16, exp_cnt = 0;

    alsup_top u_alsup_top (.*);
    alsup_panel u_alsup_panel (.ref_clk_in(ref_clk_in),
        .relay_closed_in(relay_closed_out), .keys_out(keys));

    initial
    begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    always @(negedge ref_clk_in)
    begin
        now_in <= now_in + 32'h1;
    end

    task automatic results;
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask

    task automatic do_reset;
        reset_in = 1'b1;
        cyc(20);
        reset_in = 1'b0;
        exp_cnt = 0;
        cyc(4);
    endtask

    task automatic wait_lamp(input logic v);
        int i;
        for (i = 0; i < 20 && lamp_out !== v; i++)
            cyc(1);
        if (i == 20)
        begin
            mismatches++;
            results();
        end
    endtask

    initial
    begin
        do_reset();
        chk("relay", relay_closed_out, 1);
        chk("lamp", lamp_out, 0);
        chk("count", log_out[TYP_PWR].count, 0);
        temp_cfg_in.enable = 1'b1;
        repeat (8)
        begin
            temp_raw_in = 16'($random(seed) % 1000);
            temp_trim_in = 16'($random(seed) % 50);
            cyc(4);
            chk("corr", temp_corr_out, 32'(temp_raw_in + temp_trim_in));
        end
        temp_cfg_in.enable = 1'b0;
        door1_closed_in = 1'b0;
        u_alsup_panel.press(0, 8);
        cyc(8);
        chk("run", running_out, 0);
        door1_closed_in = 1'b1;
        cyc(4);
        u_alsup_panel.press(0, 8);
        cyc(8);
        chk("run", running_out, 1);
        door2_closed_in = 1'b0;
        cyc(8);
        chk("drive", {drive_en_out, heat_en_out}, 0);
        door2_closed_in = 1'b1;
        cyc(8);
        chk("drive", {drive_en_out, heat_en_out}, 3);
        u_alsup_panel.press(1, 8);
        cyc(8);
        chk("run", running_out, 0);
        for (int e = 0; e < 4; e++)
        begin
            pwr_alarm_en_in = e[0];
            pwr_buzzer_en_in = e[1];
            was_running_in = 1'b1;
            elapsed_saved_in = $random(seed);
            power_returned_in = 1'b0;
            do_reset();
            power_returned_in = 1'b1;
            if (e[0])
                exp_cnt++;
            wait_lamp(e[0]);
            cyc(6);
            chk("run", running_out, 1);
            chk("elapsed", elapsed_out, elapsed_saved_in);
            chk("lamp", lamp_out, e[0]);
            chk("relay", relay_closed_out, !e[0]);
            chk("buzzer", buzzer_out, e[0] & e[1]);
            chk("count", log_out[TYP_PWR].count, exp_cnt);
            u_alsup_panel.press(2, 8);
            cyc(6);
            chk("ack", {lamp_out, buzzer_out, relay_closed_out}, 1);
            chk("count", log_out[TYP_PWR].count, exp_cnt);
        end
        log_clear_in = 2'(TYP_PWR);
        log_clear_stb_in = 1'b1;
        cyc(1);
        log_clear_stb_in = 1'b0;
        cyc(4);
        exp_cnt = 0;
        chk("clear", log_out[TYP_PWR].count, exp_cnt);
        chk("reports", u_alsup_panel.alarm_reports, 2);
        results();
    end
endmodule
